// ===== core/ppmc_pkg.sv
package ppmc_pkg;

  // ==========================================================
  // Register offsets in special function space
  localparam logic [7:0] ADDR_P0_UPPER_MODE = 8'had;
  localparam logic [7:0] ADDR_P1_LOWER_MODE = 8'hae;
  localparam logic [7:0] ADDR_P1_UPPER_MODE = 8'haf;
  localparam logic [7:0] ADDR_P3_LATCH = 8'hb0;
  localparam logic [7:0] ADDR_P2_LOWER_MODE = 8'hb1;
  localparam logic [7:0] ADDR_P2_UPPER_MODE = 8'hb2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int HCFG_MEM_BIT = 1;
  localparam int PIN_RD_STROBE = 7;
  localparam int PIN_WR_STROBE = 6;
  localparam int PIN_COUNT_ONE = 5;
  localparam int PIN_COUNT_ZERO = 4;
  localparam int PIN_IRQ_ONE = 3;
  localparam int PIN_IRQ_ZERO = 2;
  localparam int PIN_TXD = 1;
  localparam int PIN_RXD = 0;
  localparam logic [1:0] SER_MODE_SHIFT = 2'h0;

  // ==========================================================
  // Pin drive modes, in field encoding order
  typedef enum logic [1:0] {
    PPMC_QUASI,
    PPMC_PUSH_PULL,
    PPMC_OPEN_DRAIN,
    PPMC_INPUT
  } ppmc_mode_t;

  // Returns {pad_out, pad_oe, pull_up} for one pin
  function automatic logic [2:0] ppmc_drive(input logic [1:0] mode, input logic val);
    logic [2:0] res;
    res = 3'h0;
    unique case (ppmc_mode_t'(mode))
      PPMC_QUASI: res = {val, ~val, val};
      PPMC_PUSH_PULL: res = {val, 1'b1, 1'b0};
      PPMC_OPEN_DRAIN: res = {1'b0, ~val, 1'b0};
      PPMC_INPUT: res = 3'h0;
    endcase
    return res;
  endfunction

endpackage

// ===== core/ppmc_pin_if.sv
`timescale 1ns/1ps
interface ppmc_pin_if;
  logic [15:0] mode;
  logic [7:0] value;
  logic [7:0] ovr_en;
  logic [7:0] ovr_out;
  logic [7:0] ovr_oe;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] pad_pull;

  modport ctrl (
    output mode, value, ovr_en, ovr_out, ovr_oe,
    input pad_out, pad_oe, pad_pull
  );
  modport drv (
    input mode, value, ovr_en, ovr_out, ovr_oe,
    output pad_out, pad_oe, pad_pull
  );
endinterface

// ===== core/ppmc_pin_drv.sv
`timescale 1ns/1ps
module ppmc_pin_drv (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ppmc_pin_if.drv pins
);

  logic [7:0] next_out;
  logic [7:0] next_oe;
  logic [7:0] next_pull;

  // ==========================================================
  // Mode decode with override
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [2:0] d;
      d = ppmc_pkg::ppmc_drive(pins.mode[2*i +: 2], pins.value[i]);
      next_out[i] = pins.ovr_en[i] ? pins.ovr_out[i] : d[2];
      next_oe[i] = pins.ovr_en[i] ? pins.ovr_oe[i] : d[1];
      next_pull[i] = pins.ovr_en[i] ? 1'b0 : d[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins.pad_out <= 8'h00;
      pins.pad_oe <= 8'h00;
      pins.pad_pull <= 8'h00;
    end else begin
      pins.pad_out <= next_out;
      pins.pad_oe <= next_oe;
      pins.pad_pull <= next_pull;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_open_drain;
    !pins.ovr_en[0] && pins.mode[1:0] == 2'h2 |=>
      !pins.pad_out[0] && pins.pad_oe[0] == !$past(pins.value[0]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drive wrong");

  property p_input_only;
    !pins.ovr_en[7] && pins.mode[15:14] == 2'h3 |=> !pins.pad_oe[7] && !pins.pad_pull[7];
  endproperty
  a_input_only: assert property (p_input_only) else $error("input pin driven");

  property p_quasi;
    !pins.ovr_en[3] && pins.mode[7:6] == 2'h0 |=>
      pins.pad_pull[3] == $past(pins.value[3]) && pins.pad_oe[3] == !$past(pins.value[3]);
  endproperty
  a_quasi: assert property (p_quasi) else $error("quasi mode wrong");

  property p_push;
    !pins.ovr_en[4] && pins.mode[9:8] == 2'h1 |=>
      pins.pad_oe[4] && pins.pad_out[4] == $past(pins.value[4]);
  endproperty
  a_push: assert property (p_push) else $error("push pull wrong");

endmodule

// ===== core/ppmc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Two-bit pin field picks pull-up, push-pull, open-drain or input.
// - Low and high mode bytes per port, port 3 and port 0 low from inputs; pin 3/7 at bits 7-6.
// - All mode registers reset to zero; pads reset undriven without pull-up, quasi from the first clock.
// - Port 3 latch resets to all ones and drives its pins.
// - Port 3 pin 7 carries active-low external read strobe.
// - Port 3 pin 6 carries active-low external write strobe.
// - External memory selected forces strobes, ignoring latch and high mode.
// - Falling edge on pins 5 and 4 counts timer 1 and 0.
// - Pins 3 and 2 request enabled interrupts on edge or low.
// - Pin 1 sends serial data, or shift clock in mode 0.
// - Pin 0 receives serial data, bidirectional in mode 0.
// - External memory use overrides ports 0 and 2 regardless of mode.
module ppmc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [7:0] port0_lower_pin_mode_i,
  input wire logic [7:0] port_three_lower_pin_mode_i,
  input wire logic [7:0] port_three_upper_pin_mode_i,
  input wire logic [7:0] hardware_config_one_i,
  input wire logic external_access_pin_n_i,
  input wire logic [7:0] p0_latch_i,
  input wire logic [7:0] p1_latch_i,
  input wire logic [7:0] p2_latch_i,
  input wire logic [7:0] xmem_addr_lo_i,
  input wire logic xmem_ad_oe_i,
  input wire logic [7:0] xmem_addr_hi_i,
  input wire logic xmem_rd_n_i,
  input wire logic xmem_wr_n_i,
  input wire logic [1:0] ser0_mode_i,
  input wire logic ser0_txd_i,
  input wire logic ser0_shift_clk_i,
  input wire logic ser0_data_out_i,
  input wire logic [1:0] count_ext_en_i,
  input wire logic [1:0] irq_edge_mode_i,
  input wire logic [1:0] irq_enable_i,
  input wire logic [7:0] p3_pad_i,
  output logic [7:0] p0_pad_o,
  output logic [7:0] p0_pad_oe_o,
  output logic [7:0] p0_pull_o,
  output logic [7:0] p1_pad_o,
  output logic [7:0] p1_pad_oe_o,
  output logic [7:0] p1_pull_o,
  output logic [7:0] p2_pad_o,
  output logic [7:0] p2_pad_oe_o,
  output logic [7:0] p2_pull_o,
  output logic [7:0] p3_pad_o,
  output logic [7:0] p3_pad_oe_o,
  output logic [7:0] p3_pull_o,
  output logic counter_zero_event_o,
  output logic counter_one_event_o,
  output logic ext_irq_zero_req_o,
  output logic ext_irq_one_req_o,
  output logic serial_zero_receive_o
);

  logic [7:0] port0_upper_pin_mode;
  logic [7:0] port1_lower_pin_mode;
  logic [7:0] port1_upper_pin_mode;
  logic [7:0] port_three_output_latch;
  logic [7:0] port2_lower_pin_mode;
  logic [7:0] port2_upper_pin_mode;
  logic [7:0] next_rdata;
  logic [7:0] p3_prev;
  logic xmem_sel;
  logic alt_txd;
  logic alt_rxd;
  logic p3_fall_zero;
  logic p3_fall_one;
  logic p3_fall_i0;
  logic p3_fall_i1;

  ppmc_pin_if p0_if ();
  ppmc_pin_if p1_if ();
  ppmc_pin_if p2_if ();
  ppmc_pin_if p3_if ();

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_upper_pin_mode <= ppmc_pkg::MODE_RESET;
      port1_lower_pin_mode <= ppmc_pkg::MODE_RESET;
      port1_upper_pin_mode <= ppmc_pkg::MODE_RESET;
      port2_lower_pin_mode <= ppmc_pkg::MODE_RESET;
      port2_upper_pin_mode <= ppmc_pkg::MODE_RESET;
      port_three_output_latch <= ppmc_pkg::LATCH_RESET;
    end else if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        ppmc_pkg::ADDR_P0_UPPER_MODE: port0_upper_pin_mode <= sfr_wdata_i;
        ppmc_pkg::ADDR_P1_LOWER_MODE: port1_lower_pin_mode <= sfr_wdata_i;
        ppmc_pkg::ADDR_P1_UPPER_MODE: port1_upper_pin_mode <= sfr_wdata_i;
        ppmc_pkg::ADDR_P3_LATCH: port_three_output_latch <= sfr_wdata_i;
        ppmc_pkg::ADDR_P2_LOWER_MODE: port2_lower_pin_mode <= sfr_wdata_i;
        ppmc_pkg::ADDR_P2_UPPER_MODE: port2_upper_pin_mode <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Register reads, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (sfr_addr_i)
      ppmc_pkg::ADDR_P0_UPPER_MODE: next_rdata = port0_upper_pin_mode;
      ppmc_pkg::ADDR_P1_LOWER_MODE: next_rdata = port1_lower_pin_mode;
      ppmc_pkg::ADDR_P1_UPPER_MODE: next_rdata = port1_upper_pin_mode;
      ppmc_pkg::ADDR_P3_LATCH: next_rdata = port_three_output_latch;
      ppmc_pkg::ADDR_P2_LOWER_MODE: next_rdata = port2_lower_pin_mode;
      ppmc_pkg::ADDR_P2_UPPER_MODE: next_rdata = port2_upper_pin_mode;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= ppmc_pkg::RDATA_RESET;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // Pin control and overrides
  assign xmem_sel = !external_access_pin_n_i || hardware_config_one_i[ppmc_pkg::HCFG_MEM_BIT];
  assign alt_txd = (ser0_mode_i == ppmc_pkg::SER_MODE_SHIFT) ? ser0_shift_clk_i : ser0_txd_i;
  assign alt_rxd = (ser0_mode_i == ppmc_pkg::SER_MODE_SHIFT) ? ser0_data_out_i : 1'b1;

  assign p0_if.mode = {port0_upper_pin_mode, port0_lower_pin_mode_i};
  assign p0_if.value = p0_latch_i;
  assign p0_if.ovr_en = {8{xmem_sel}};
  assign p0_if.ovr_out = xmem_addr_lo_i;
  assign p0_if.ovr_oe = {8{xmem_ad_oe_i}};

  assign p1_if.mode = {port1_upper_pin_mode, port1_lower_pin_mode};
  assign p1_if.value = p1_latch_i;
  assign p1_if.ovr_en = 8'h00;
  assign p1_if.ovr_out = 8'h00;
  assign p1_if.ovr_oe = 8'h00;

  assign p2_if.mode = {port2_upper_pin_mode, port2_lower_pin_mode};
  assign p2_if.value = p2_latch_i;
  assign p2_if.ovr_en = {8{xmem_sel}};
  assign p2_if.ovr_out = xmem_addr_hi_i;
  assign p2_if.ovr_oe = 8'hff;

  // Latch zero holds an alternate function low
  assign p3_if.mode = {port_three_upper_pin_mode_i, port_three_lower_pin_mode_i};
  assign p3_if.value = port_three_output_latch &
    {xmem_rd_n_i, xmem_wr_n_i, 4'hf, alt_txd, alt_rxd};
  assign p3_if.ovr_en = {xmem_sel, xmem_sel, 6'h00};
  assign p3_if.ovr_out = {xmem_rd_n_i, xmem_wr_n_i, 6'h00};
  assign p3_if.ovr_oe = 8'hc0;

  ppmc_pin_drv u_p0 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pins(p0_if));
  ppmc_pin_drv u_p1 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pins(p1_if));
  ppmc_pin_drv u_p2 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pins(p2_if));
  ppmc_pin_drv u_p3 (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pins(p3_if));

  assign p0_pad_o = p0_if.pad_out;
  assign p0_pad_oe_o = p0_if.pad_oe;
  assign p0_pull_o = p0_if.pad_pull;
  assign p1_pad_o = p1_if.pad_out;
  assign p1_pad_oe_o = p1_if.pad_oe;
  assign p1_pull_o = p1_if.pad_pull;
  assign p2_pad_o = p2_if.pad_out;
  assign p2_pad_oe_o = p2_if.pad_oe;
  assign p2_pull_o = p2_if.pad_pull;
  assign p3_pad_o = p3_if.pad_out;
  assign p3_pad_oe_o = p3_if.pad_oe;
  assign p3_pull_o = p3_if.pad_pull;

  // ==========================================================
  // Port 3 input events
  assign p3_fall_zero = p3_prev[ppmc_pkg::PIN_COUNT_ZERO] && !p3_pad_i[ppmc_pkg::PIN_COUNT_ZERO];
  assign p3_fall_one = p3_prev[ppmc_pkg::PIN_COUNT_ONE] && !p3_pad_i[ppmc_pkg::PIN_COUNT_ONE];
  assign p3_fall_i0 = p3_prev[ppmc_pkg::PIN_IRQ_ZERO] && !p3_pad_i[ppmc_pkg::PIN_IRQ_ZERO];
  assign p3_fall_i1 = p3_prev[ppmc_pkg::PIN_IRQ_ONE] && !p3_pad_i[ppmc_pkg::PIN_IRQ_ONE];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p3_prev <= 8'hff;
      counter_zero_event_o <= 1'b0;
      counter_one_event_o <= 1'b0;
    end else begin
      p3_prev <= p3_pad_i;
      counter_zero_event_o <= count_ext_en_i[0] && p3_fall_zero;
      counter_one_event_o <= count_ext_en_i[1] && p3_fall_one;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_irq_zero_req_o <= 1'b0;
      ext_irq_one_req_o <= 1'b0;
    end else begin
      ext_irq_zero_req_o <= irq_enable_i[0] && (irq_edge_mode_i[0] ? p3_fall_i0 :
        !p3_pad_i[ppmc_pkg::PIN_IRQ_ZERO]);
      ext_irq_one_req_o <= irq_enable_i[1] && (irq_edge_mode_i[1] ? p3_fall_i1 :
        !p3_pad_i[ppmc_pkg::PIN_IRQ_ONE]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_zero_receive_o <= 1'b1;
    end else begin
      serial_zero_receive_o <= p3_pad_i[ppmc_pkg::PIN_RXD];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_reset_values;
    $rose(rst_n_i) |-> port1_lower_pin_mode == 8'h00 && port2_upper_pin_mode == 8'h00
      && port_three_output_latch == 8'hff;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values");

  property p_mode_write;
    sfr_wr_i && sfr_addr_i == 8'hb2 |=> port2_upper_pin_mode == $past(sfr_wdata_i);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_latch_read;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hb0 |=> sfr_rdata_o == $past(port_three_output_latch);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");

  property p_rd_strobe;
    xmem_sel && !xmem_rd_n_i |=> p3_pad_oe_o[7] && !p3_pad_o[7];
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");

  property p_wr_strobe;
    xmem_sel && !xmem_wr_n_i && port_three_output_latch[6] == 1'b0 |=> p3_pad_oe_o[6] && !p3_pad_o[6];
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

  property p_count_one;
    count_ext_en_i[1] && p3_fall_one |=> counter_one_event_o ##1 !counter_one_event_o;
  endproperty
  a_count_one: assert property (p_count_one) else $error("counter event wrong");

  property p_irq_level;
    irq_enable_i[1] && !irq_edge_mode_i[1] && !p3_pad_i[3] |=> ext_irq_one_req_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level irq missing");

  property p_irq_off;
    !irq_enable_i[0] |=> !ext_irq_zero_req_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("disabled irq raised");

  property p_shift_clk;
    ser0_mode_i == 2'h0 && port_three_lower_pin_mode_i[3:2] == 2'h1 |=>
      p3_pad_o[1] == $past(ser0_shift_clk_i && port_three_output_latch[1]);
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock wrong");

  property p_rxd;
    1'b1 |=> serial_zero_receive_o == $past(p3_pad_i[0]);
  endproperty
  a_rxd: assert property (p_rxd) else $error("receive path wrong");

  property p_p0_override;
    xmem_sel |=> p0_pad_o == $past(xmem_addr_lo_i) && p0_pull_o == 8'h00;
  endproperty
  a_p0_override: assert property (p_p0_override) else $error("port 0 not overridden");

  c_xmem_read: cover property (xmem_sel && !xmem_rd_n_i ##1 xmem_rd_n_i);
  c_count_zero: cover property (counter_zero_event_o);
  c_irq_edge: cover property (irq_edge_mode_i[0] && ext_irq_zero_req_o);
  c_latch_write: cover property (sfr_wr_i && sfr_addr_i == 8'hb0 && sfr_wdata_i == 8'h00);

endmodule

// ===== bench/ppmc_board_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board side of port 3: pad driver, external source, pull-up
module ppmc_board_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pull_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  logic [7:0] last = 8'hff;

  // Undriven pin without pull-up wanders
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) level_o[i] = pad_o_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pull_i[i]) level_o[i] = 1'b1;
      else level_o[i] = ~last[i];
    end
  end

  always @(posedge clk_sys_i) last <= level_o;
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module tb;
  // ==========================================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  logic [7:0] port0_lower_pin_mode_i = 8'h00, port_three_lower_pin_mode_i = 8'h00;
  logic [7:0] port_three_upper_pin_mode_i = 8'h00, hardware_config_one_i = 8'h00;
  logic external_access_pin_n_i = 1'b1, xmem_ad_oe_i = 1'b0, xmem_rd_n_i = 1'b1;
  logic xmem_wr_n_i = 1'b1, ser0_txd_i = 1'b1, ser0_shift_clk_i = 1'b1, ser0_data_out_i = 1'b1;
  logic [7:0] p0_latch_i = 8'hff, p1_latch_i = 8'hff, p2_latch_i = 8'hff;
  logic [7:0] xmem_addr_lo_i = 8'h00, xmem_addr_hi_i = 8'h00;
  logic [1:0] ser0_mode_i = 2'h1, count_ext_en_i = 2'h0;
  logic [1:0] irq_edge_mode_i = 2'h0, irq_enable_i = 2'h0;
  logic [7:0] p3_pad_i, sfr_rdata_o, p0_pad_o, p0_pad_oe_o, p0_pull_o, p1_pad_o, p1_pad_oe_o;
  logic [7:0] p1_pull_o, p2_pad_o, p2_pad_oe_o, p2_pull_o, p3_pad_o, p3_pad_oe_o, p3_pull_o;
  logic counter_zero_event_o, counter_one_event_o, ext_irq_zero_req_o, ext_irq_one_req_o;
  logic serial_zero_receive_o, lvl_i0, rx_low;
  logic [7:0] ext_val = 8'hff, ext_en = 8'h00;
  int err_count = 0, total_checks = 0, n_c1, n_c0, n_i1, n_i0;
  logic [7:0] adr [6] = '{ppmc_pkg::ADDR_P0_UPPER_MODE, ppmc_pkg::ADDR_P1_LOWER_MODE,
    ppmc_pkg::ADDR_P1_UPPER_MODE, ppmc_pkg::ADDR_P3_LATCH, ppmc_pkg::ADDR_P2_LOWER_MODE,
    ppmc_pkg::ADDR_P2_UPPER_MODE};

  always #50 clk_sys_i = ~clk_sys_i;

  ppmc_top u_dut (
    .clk_sys_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o,
    .port0_lower_pin_mode_i, .port_three_lower_pin_mode_i, .port_three_upper_pin_mode_i,
    .hardware_config_one_i, .external_access_pin_n_i, .p0_latch_i, .p1_latch_i, .p2_latch_i,
    .xmem_addr_lo_i, .xmem_ad_oe_i, .xmem_addr_hi_i, .xmem_rd_n_i, .xmem_wr_n_i, .ser0_mode_i,
    .ser0_txd_i, .ser0_shift_clk_i, .ser0_data_out_i, .count_ext_en_i, .irq_edge_mode_i,
    .irq_enable_i, .p3_pad_i, .p0_pad_o, .p0_pad_oe_o, .p0_pull_o, .p1_pad_o, .p1_pad_oe_o,
    .p1_pull_o, .p2_pad_o, .p2_pad_oe_o, .p2_pull_o, .p3_pad_o, .p3_pad_oe_o, .p3_pull_o,
    .counter_zero_event_o, .counter_one_event_o, .ext_irq_zero_req_o, .ext_irq_one_req_o,
    .serial_zero_receive_o
  );

  ppmc_board_model u_board (.clk_sys_i, .pad_o_i(p3_pad_o), .pad_oe_i(p3_pad_oe_o),
    .pull_i(p3_pull_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(p3_pad_i));

  // ==========================================================
  // Helpers
  function automatic logic [23:0] exp_port(input logic [15:0] m, input logic [7:0] v);
    logic [7:0] p, oe, pu;
    for (int i = 0; i < 8; i++) begin
      case (m[2*i +: 2])
        2'h0: {p[i], oe[i], pu[i]} = {v[i], ~v[i], v[i]};
        2'h1: {p[i], oe[i], pu[i]} = {v[i], 2'b10};
        2'h2: {p[i], oe[i], pu[i]} = {1'b0, ~v[i], 1'b0};
        default: {p[i], oe[i], pu[i]} = 3'h0;
      endcase
    end
    return {p, oe, pu};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_sys_i);
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      `CHK("reset value", (i == 3) ? 8'hff : 8'h00, d)
    end
    `CHK("port1 at reset", exp_port(16'h0, 8'hff), {p1_pad_o, p1_pad_oe_o, p1_pull_o})
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 6; i++) wr(adr[i], 8'h96 ^ 8'(i));
    wr(8'hb3, 8'h55);
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      `CHK("reg readback", 8'h96 ^ 8'(i), d)
    end
    rd(8'hb3, d);
    `CHK("unmapped read", 8'h00, d)
  endtask

  task automatic t_modes();
    logic [7:0] pat [3] = '{8'h00, 8'hff, 8'ha5};
    port0_lower_pin_mode_i = 8'h1e;
    for (int i = 0; i < 6; i++) if (i != 3) wr(adr[i], (i == 1 || i == 4) ? 8'h1e : 8'he1);
    foreach (pat[k]) begin
      {p0_latch_i, p1_latch_i, p2_latch_i} = {3{pat[k]}};
      settle();
      `CHK("port0 drive", exp_port(16'he11e, pat[k]), {p0_pad_o, p0_pad_oe_o, p0_pull_o})
      `CHK("port1 drive", exp_port(16'he11e, pat[k]), {p1_pad_o, p1_pad_oe_o, p1_pull_o})
      `CHK("port2 drive", exp_port(16'he11e, pat[k]), {p2_pad_o, p2_pad_oe_o, p2_pull_o})
    end
  endtask

  task automatic p3_case(input logic [5:0] ctl, input logic [7:0] v);
    {xmem_rd_n_i, xmem_wr_n_i, ser0_mode_i[0], ser0_txd_i, ser0_shift_clk_i,
      ser0_data_out_i} = ctl;
    settle();
    `CHK("port3 drive", exp_port(16'h0004, v), {p3_pad_o, p3_pad_oe_o, p3_pull_o})
  endtask

  // Pin 1 push-pull so the shift clock shows up as driven
  task automatic t_port3();
    port_three_lower_pin_mode_i = 8'h04;
    wr(ppmc_pkg::ADDR_P3_LATCH, 8'h00);
    p3_case(6'b111111, 8'h00);
    wr(ppmc_pkg::ADDR_P3_LATCH, 8'hff);
    p3_case(6'b011111, 8'h7f);
    p3_case(6'b101111, 8'hbf);
    p3_case(6'b111011, 8'hfd);
    p3_case(6'b110100, 8'hfc);
    p3_case(6'b110011, 8'hff);
    p3_case(6'b111111, 8'hff);
  endtask

  task automatic t_xmem();
    logic [5:0] exp_st;
    wr(ppmc_pkg::ADDR_P3_LATCH, 8'h00);
    port_three_upper_pin_mode_i = 8'hff;
    xmem_ad_oe_i = 1'b1;
    {xmem_addr_lo_i, xmem_addr_hi_i} = 16'h3cc3;
    for (int k = 0; k < 2; k++) begin
      hardware_config_one_i = k ? 8'h00 : 8'h02;
      external_access_pin_n_i = k ? 1'b0 : 1'b1;
      {xmem_rd_n_i, xmem_wr_n_i} = k ? 2'b10 : 2'b01;
      exp_st = k ? 6'b101100 : 6'b011100;
      settle();
      `CHK("strobes", exp_st, {p3_pad_o[7:6], p3_pad_oe_o[7:6], p3_pull_o[7:6]})
      `CHK("port0 bus", 24'h3cff00, {p0_pad_o, p0_pad_oe_o, p0_pull_o})
      `CHK("port2 bus", 24'hc3ff00, {p2_pad_o, p2_pad_oe_o, p2_pull_o})
    end
    {hardware_config_one_i, external_access_pin_n_i, xmem_rd_n_i, xmem_wr_n_i} = {8'h00, 3'b111};
    wr(ppmc_pkg::ADDR_P3_LATCH, 8'hff);
  endtask

  // Pull one pin low for four cycles, counting what the block reports
  task automatic fall(input int pin);
    {n_c1, n_c0, n_i1, n_i0} = '0;
    ext_val[pin] = 1'b0;
    repeat (4) begin
      @(negedge clk_sys_i);
      n_c1 += int'(counter_one_event_o === 1'b1);
      n_c0 += int'(counter_zero_event_o === 1'b1);
      n_i1 += int'(ext_irq_one_req_o === 1'b1);
      n_i0 += int'(ext_irq_zero_req_o === 1'b1);
    end
    {lvl_i0, rx_low} = {ext_irq_zero_req_o, serial_zero_receive_o};
    ext_val[pin] = 1'b1;
    settle();
  endtask

  task automatic t_events();
    {port_three_lower_pin_mode_i, port_three_upper_pin_mode_i, ext_en} = {3{8'hff}};
    count_ext_en_i = 2'b10;
    settle();
    fall(5);
    `CHK("timer1 count", 1, n_c1)
    fall(4);
    `CHK("timer0 disabled", 0, n_c0)
    count_ext_en_i = 2'b11;
    fall(4);
    `CHK("timer0 count", 1, n_c0)
    {irq_enable_i, irq_edge_mode_i} = 4'b1110;
    fall(3);
    `CHK("irq1 edge", 1, n_i1)
    fall(2);
    `CHK("irq0 level", 1'b1, lvl_i0)
    `CHK("irq0 released", 1'b0, ext_irq_zero_req_o)
    {irq_enable_i, irq_edge_mode_i} = 4'b1101;
    fall(3);
    `CHK("irq1 level", 4, n_i1)
    fall(2);
    `CHK("irq0 edge", 1, n_i0)
    irq_enable_i = 2'b00;
    fall(3);
    `CHK("irq1 disabled", 0, n_i1)
    fall(2);
    `CHK("irq0 disabled", 0, n_i0)
    fall(0);
    `CHK("rx low", 1'b0, rx_low)
    `CHK("rx high", 1'b1, serial_zero_receive_o)
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    t_reset();
    t_regs();
    t_modes();
    t_port3();
    t_xmem();
    t_events();
    end_of_test();
  end

  // Tests need well under 1000 cycles
  initial begin
    #(1_000_000);
    err_count++;
    end_of_test();
  end
endmodule
